// [verilog/tape_reader_cfg.svh]
// Timing counts and reset values for the tape reader drive controller
`ifndef TAPE_READER_CFG_SVH
`define TAPE_READER_CFG_SVH

`define CLK_PERIOD_NS 40
`define STEP_FULL_NS 1667000
`define STEP_START_NS 5000000
`define STEP_SLOW_NS 20000000
`define ACCEL_STEPS 30
`define PERIOD_W 20
`define HOLE_W 8
`define SENSE_W 9
`define FEED_HOLE_BIT 8
`define PHASE_RESET 2'h0

`endif

// [verilog/tape_reader_pkg.sv]
// Types shared by the tape reader drive controller
package tape_reader_pkg;
`include "tape_reader_cfg.svh"

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_FEED = 2'b01,
      ST_SLOW = 2'b10
   } feed_state_e;

   typedef struct packed {
      feed_state_e state;
      logic [1:0] phase;
      logic [`PERIOD_W-1:0] period;
      logic [`SENSE_W-1:0] sync1;
      logic [`SENSE_W-1:0] sync2;
      logic [`HOLE_W-1:0] data;
      logic valid;
      logic tape_out;
      logic boost;
   } drive_s;

   typedef struct packed {
      logic [`PERIOD_W-1:0] cnt;
      logic tick;
   } timer_s;

endpackage : tape_reader_pkg

// [verilog/step_timer.sv]
// Step period timer: one-cycle tick every period_i cycles while enabled
`timescale 1ns/1ns
`include "tape_reader_cfg.svh"
module step_timer
   import tape_reader_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Control
   input wire logic en_i,
   input wire logic [`PERIOD_W-1:0] period_i,
   // Step enable
   output logic tick_o
);
   timer_s r_reg;
   timer_s r_next;

   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (!en_i) begin
         r_next.cnt = '0;
      end else if (r_reg.cnt >= period_i - `PERIOD_W'(1)) begin
         r_next.cnt = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.cnt = r_reg.cnt + `PERIOD_W'(1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tick_o = r_reg.tick;
endmodule : step_timer

// [verilog/tape_reader_stepper_drive.sv]
// Controller that steps the tape reader motor and samples its hole sensors
`timescale 1ns/1ns
`include "tape_reader_cfg.svh"
module tape_reader_stepper_drive
   import tape_reader_pkg::*;
#(
   parameter int unsigned STEP_FULL_CYC = `STEP_FULL_NS / `CLK_PERIOD_NS,
   parameter int unsigned STEP_START_CYC = `STEP_START_NS / `CLK_PERIOD_NS,
   parameter int unsigned STEP_SLOW_CYC = `STEP_SLOW_NS / `CLK_PERIOD_NS
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // User side
   input wire logic feed_i,
   input wire logic slow_i,
   input wire logic clear_tape_out_i,
   output logic [`HOLE_W-1:0] data_o,
   output logic data_valid_o,
   output logic tape_out_o,
   output logic feeding_o,
   // Reader pins
   output logic sel_a0_o,
   output logic sel_a1_o,
   output logic sel_b0_o,
   output logic sel_b1_o,
   output logic boost_o,
   input wire logic [`HOLE_W-1:0] hole_i,
   input wire logic feed_hole_i
);
   localparam logic [`PERIOD_W-1:0] P_FULL = `PERIOD_W'(STEP_FULL_CYC);
   localparam logic [`PERIOD_W-1:0] P_START = `PERIOD_W'(STEP_START_CYC);
   localparam logic [`PERIOD_W-1:0] P_SLOW = `PERIOD_W'(STEP_SLOW_CYC);
   localparam logic [`PERIOD_W-1:0] P_DEC =
      `PERIOD_W'((STEP_START_CYC - STEP_FULL_CYC + `ACCEL_STEPS - 2) / (`ACCEL_STEPS - 1));

   drive_s r_reg;
   drive_s r_next;
   logic step_tick;
   logic feed_ok;
   logic at_char;

   function automatic logic [1:0] next_phase(input logic [1:0] ph);
      logic [1:0] res;
      res = ph;
      case (ph)
         2'h0: res = 2'h2;
         2'h2: res = 2'h3;
         2'h3: res = 2'h1;
         default: res = 2'h0;
      endcase
      return res;
   endfunction : next_phase

   step_timer i_step_timer (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .en_i(r_reg.state != ST_HOLD),
      .period_i(r_reg.period),
      .tick_o(step_tick)
   );

   assign feed_ok = feed_i && !r_reg.tape_out;
   assign at_char = (r_reg.phase[1] == r_reg.phase[0]);

   always_comb begin
      r_next = r_reg;
      r_next.valid = 1'b0;
      r_next.sync1 = {feed_hole_i, hole_i};
      r_next.sync2 = r_reg.sync1;
      if (clear_tape_out_i) begin
         r_next.tape_out = 1'b0;
      end
      case (r_reg.state)
         ST_HOLD: begin
            r_next.boost = 1'b0;
            if (feed_ok) begin
               r_next.boost = 1'b1;
               if (slow_i) begin
                  r_next.state = ST_SLOW;
                  r_next.period = P_SLOW;
               end else begin
                  r_next.state = ST_FEED;
                  r_next.period = P_START;
               end
            end
         end
         default: begin
            if (!feed_ok) begin
               // Selects stay put so the motor holds its place
               r_next.state = ST_HOLD;
               r_next.boost = 1'b0;
            end else if (step_tick) begin
               if (at_char) begin
                  if (r_reg.sync2[`FEED_HOLE_BIT]) begin
                     r_next.data = r_reg.sync2[`HOLE_W-1:0];
                     r_next.valid = 1'b1;
                  end
               end else if (r_reg.sync2[`FEED_HOLE_BIT]) begin
                  r_next.tape_out = 1'b1;
               end
               r_next.phase = next_phase(r_reg.phase);
               if (r_reg.state == ST_FEED) begin
                  if (r_reg.period - P_FULL > P_DEC) begin
                     r_next.period = r_reg.period - P_DEC;
                  end else begin
                     r_next.period = P_FULL;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         r_reg <= '0;
         r_reg.state <= ST_HOLD;
         r_reg.phase <= `PHASE_RESET;
         r_reg.period <= P_START;
      end else begin
         r_reg <= r_next;
      end
   end

   // Pin drive: exactly one select per side, inactive ones low
   assign sel_a1_o = r_reg.phase[1];
   assign sel_a0_o = !r_reg.phase[1];
   assign sel_b1_o = r_reg.phase[0];
   assign sel_b0_o = !r_reg.phase[0];
   assign boost_o = r_reg.boost;
   assign data_o = r_reg.data;
   assign data_valid_o = r_reg.valid;
   assign tape_out_o = r_reg.tape_out;
   assign feeding_o = (r_reg.state != ST_HOLD);

   // Checking helpers
   logic [`PERIOD_W-1:0] gap_reg;
   logic gap_ok_reg;
   logic [4:0] steps_reg;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || r_reg.state == ST_HOLD) begin
         gap_reg <= `PERIOD_W'(1);
         gap_ok_reg <= 1'b0;
         steps_reg <= 5'h00;
      end else if (step_tick) begin
         gap_reg <= `PERIOD_W'(1);
         gap_ok_reg <= 1'b1;
         if (steps_reg != 5'h1f) begin
            steps_reg <= steps_reg + 5'h01;
         end
      end else begin
         gap_reg <= gap_reg + `PERIOD_W'(1);
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   sequence feeding_s;
      r_reg.state != ST_HOLD;
   endsequence
   sequence stopped_s;
      r_reg.state == ST_HOLD;
   endsequence

   select_one_a: assert property ((sel_a0_o ^ sel_a1_o) && (sel_b0_o ^ sel_b1_o))
      else $error("select lines not one per side");
   one_change_a: assert property ($changed(r_reg.phase) |->
      $countones(r_reg.phase ^ $past(r_reg.phase)) == 1)
      else $error("more than one select changed");
   step_order_a: assert property ($changed(r_reg.phase) |->
      r_reg.phase == next_phase($past(r_reg.phase)))
      else $error("step pattern out of order");
   boost_feed_a: assert property (feeding_s |-> boost_o)
      else $error("boost low while feeding");
   stop_hold_a: assert property (feeding_s ##1 stopped_s |->
      !boost_o && $stable(r_reg.phase))
      else $error("stop did not hold last position");
   step_gap_a: assert property (step_tick && gap_ok_reg && r_reg.state != ST_HOLD |->
      gap_reg == r_reg.period)
      else $error("step spacing differs from period");
   accel_done_a: assert property (r_reg.state == ST_FEED && steps_reg >= 5'h1d |->
      r_reg.period == P_FULL)
      else $error("full rate not reached in time");
   no_overspeed_a: assert property (feeding_s |-> r_reg.period >= P_FULL)
      else $error("step period below full rate");
   slow_rate_a: assert property (r_reg.state == ST_SLOW |-> r_reg.period == P_SLOW)
      else $error("slow mode period wrong");
   sample_point_a: assert property ($rose(data_valid_o) |->
      $past(step_tick) && $past(at_char))
      else $error("sample taken off character position");
   tape_out_a: assert property ($rose(tape_out_o) |->
      $past(step_tick && !at_char && r_reg.sync2[`FEED_HOLE_BIT]))
      else $error("tape out set without feed hole between characters");
   step_on_tick_a: assert property ($changed(r_reg.phase) |->
      $past(step_tick) && $past(r_reg.state != ST_HOLD))
      else $error("select changed without a step tick");
   hold_quiet_a: assert property (stopped_s |-> !boost_o)
      else $error("boost high while holding");
   tape_sticky_a: assert property (tape_out_o && !clear_tape_out_i |=> tape_out_o)
      else $error("tape out dropped without clear");
   tape_refuse_a: assert property (r_reg.state == ST_HOLD && tape_out_o |=>
      r_reg.state == ST_HOLD)
      else $error("feed started while tape out");
   valid_pulse_a: assert property (data_valid_o |=> !data_valid_o)
      else $error("capture strobe longer than one cycle");
endmodule : tape_reader_stepper_drive

// [test/tape_reader_model.sv]
// Behavioural tape reader: stepping motor and hole sensors
`timescale 1ns/1ns
module tape_reader_model (
   // Motor drive
   input wire logic sel_a0_i,
   input wire logic sel_a1_i,
   input wire logic sel_b0_i,
   input wire logic sel_b1_i,
   input wire logic boost_i,
   // Sensors
   input wire logic no_tape_i,
   output logic [7:0] hole_o,
   output logic feed_hole_o
);
   int steps = 0;
   // Only a boosted pair change turns the shaft
   always @(sel_a1_i or sel_b1_i) begin
      if (boost_i === 1'b1) steps = steps + 1;
   end
   // Odd steps sit between characters: no feed hole, junk data
   always_comb begin
      if (no_tape_i) {feed_hole_o, hole_o} = 9'h1ff;
      else if (steps[0]) {feed_hole_o, hole_o} = {1'b0, ~8'(steps / 2 * 37 + 5)};
      else {feed_hole_o, hole_o} = {1'b1, 8'(steps / 2 * 37 + 5)};
   end
endmodule : tape_reader_model

// [test/tape_reader_stepper_drive_test.sv]
// Self-checking bench for the tape reader drive controller
`timescale 1ns/1ns
module tape_reader_stepper_drive_test;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic feed_i = 1'b0;
   logic slow_i = 1'b0;
   logic clr = 1'b0;
   logic no_tape = 1'b0;
   logic [7:0] data_o, hole;
   logic data_valid_o, tape_out_o, feeding_o, feed_hole;
   logic sel_a0_o, sel_a1_o, sel_b0_o, sel_b1_o, boost_o;
   logic [1:0] ph = 2'h0;
   int errors = 0, tests_run = 0, cyc = 0, last = 0, nstep = 0, ncap = 0;
   int gaps [128];
   always #20 clk_sys_i = ~clk_sys_i;
   tape_reader_stepper_drive #(.STEP_FULL_CYC(20), .STEP_START_CYC(80), .STEP_SLOW_CYC(200))
      i_tape_reader_stepper_drive (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .feed_i(feed_i),
      .slow_i(slow_i), .clear_tape_out_i(clr), .data_o(data_o), .data_valid_o(data_valid_o),
      .tape_out_o(tape_out_o), .feeding_o(feeding_o), .sel_a0_o(sel_a0_o),
      .sel_a1_o(sel_a1_o), .sel_b0_o(sel_b0_o), .sel_b1_o(sel_b1_o), .boost_o(boost_o),
      .hole_i(hole), .feed_hole_i(feed_hole));
   tape_reader_model i_tape_reader_model (.sel_a0_i(sel_a0_o), .sel_a1_i(sel_a1_o),
      .sel_b0_i(sel_b0_o), .sel_b1_i(sel_b1_o), .boost_i(boost_o), .no_tape_i(no_tape),
      .hole_o(hole), .feed_hole_o(feed_hole));
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask : check
   task automatic close_out();
      $display("errors %0d, tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   // Step and capture monitor, plus the run ceiling
   always @(posedge clk_sys_i) begin
      cyc++;
      if (!srst_i && {sel_a1_o, sel_b1_o} !== ph) begin
         check("step order", {~ph[0], ph[1]}, {sel_a1_o, sel_b1_o});
         check("one per side", 2'h3, {sel_a0_o ^ sel_a1_o, sel_b0_o ^ sel_b1_o});
         check("boost on step", 1'b1, boost_o);
         ph = {sel_a1_o, sel_b1_o};
         nstep++;
         gaps[nstep] = cyc - last;
         last = cyc;
      end
      if (data_valid_o === 1'b1) begin
         check("data", no_tape ? 8'hff : 8'(ncap * 37 + 5), data_o);
         check("capture phase", 1'b1, sel_a1_o ^ sel_b1_o);
         ncap++;
      end
      if (cyc == 10000) begin
         errors++;
         close_out();
      end
   end
   task automatic wait_steps(int n);
      for (int i = 0; i < 5000 && nstep < n; i++) @(posedge clk_sys_i);
   endtask : wait_steps
   task automatic t_reset();
      check("reset selects", 4'ha, {sel_a0_o, sel_a1_o, sel_b0_o, sel_b1_o});
      check("reset flags", 4'h0, {boost_o, feeding_o, tape_out_o, data_valid_o});
   endtask : t_reset
   task automatic t_cont();
      int s;
      s = nstep;
      feed_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      check("boost up", 2'h3, {boost_o, feeding_o});
      wait_steps(s + 31);
      check("soft start", 1'b1, gaps[s + 2] > 20);
      check("accel within 30", 20, gaps[s + 30]);
      check("full rate gap", 20, gaps[s + 31]);
   endtask : t_cont
   task automatic t_stop();
      logic [3:0] sel;
      int n;
      feed_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      check("stop flags", 2'h0, {boost_o, feeding_o});
      sel = {sel_a0_o, sel_a1_o, sel_b0_o, sel_b1_o};
      n = nstep;
      repeat (100) @(posedge clk_sys_i);
      check("hold selects", sel, {sel_a0_o, sel_a1_o, sel_b0_o, sel_b1_o});
      check("hold still", n, nstep);
   endtask : t_stop
   task automatic t_slow();
      int s;
      s = nstep;
      feed_i <= 1'b1;
      slow_i <= 1'b1;
      wait_steps(s + 3);
      check("slow gap", 200, gaps[s + 3]);
   endtask : t_slow
   task automatic t_tape_out();
      no_tape <= 1'b1;
      slow_i <= 1'b0;
      feed_i <= 1'b1;
      for (int i = 0; i < 500 && tape_out_o !== 1'b1; i++) @(posedge clk_sys_i);
      repeat (50) @(posedge clk_sys_i);
      check("tape out", 3'h4, {tape_out_o, feeding_o, boost_o});
      feed_i <= 1'b0;
      no_tape <= 1'b0;
      clr <= 1'b1;
      @(posedge clk_sys_i);
      clr <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      check("tape out cleared", 1'b0, tape_out_o);
   endtask : t_tape_out
   initial begin
      repeat (20) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(posedge clk_sys_i);
      t_reset();
      t_cont();
      t_stop();
      t_slow();
      t_stop();
      t_tape_out();
      close_out();
   end
endmodule : tape_reader_stepper_drive_test
